/* File: hw/scc_ramp.sv */
// Rate limiter stepping once per millisecond tick
`include "scc_regs.svh"
module scc_ramp (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic tick_in,
  input wire logic en_in,
  input wire logic signed [15:0] target_in,
  input wire logic [13:0] up_ms_in,
  input wire logic [13:0] dn_ms_in,
  // Result
  output logic signed [15:0] value_out
);
  import scc_pkg::*;
  logic signed [39:0] acc_q;
  logic signed [39:0] acc_d;
  logic signed [39:0] tgt;
  logic signed [39:0] step_up;
  logic signed [39:0] step_dn;

  always_comb begin
    tgt = 40'(target_in) <<< `SCC_RPM_FRAC;
    // Zero time would divide by zero, so it acts as the shortest time
    step_up = (`SCC_RAMP_RPM << `SCC_RPM_FRAC) / 40'((up_ms_in == 14'h0) ? 14'h1 : up_ms_in);
    step_dn = (`SCC_RAMP_RPM << `SCC_RPM_FRAC) / 40'((dn_ms_in == 14'h0) ? 14'h1 : dn_ms_in);
    acc_d = acc_q;
    if (!en_in) begin
      acc_d = tgt;
    end else if (tick_in && acc_q < tgt) begin
      acc_d = (acc_q + step_up > tgt) ? tgt : acc_q + step_up;
    end else if (tick_in && acc_q > tgt) begin
      acc_d = (acc_q - step_dn < tgt) ? tgt : acc_q - step_dn;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc_q <= 40'h0;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign value_out = acc_q[31:16];

  a_ramp_up_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    en_in && $past(en_in) |-> acc_q - $past(acc_q) <= $past(step_up))
    else $error("ramp rose faster than the set time allows");
  a_ramp_dn_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    en_in && $past(en_in) |-> $past(acc_q) - acc_q <= $past(step_dn))
    else $error("ramp fell faster than the set time allows");
endmodule : scc_ramp

/* File: hw/scc_top.sv */
// Servo command conditioner: torque limits, speed path, brake timing, AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`include "scc_regs.svh"
module scc_top #(
  parameter int MS_CYCLES = `SCC_MS_NS / `SCC_CLK_NS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Drive terminals and samples
  input scc_pkg::scc_pins_t pins_in,
  input scc_pkg::scc_ana_t ana_in,
  // Conditioned commands
  output scc_pkg::scc_cmd_t cmd_out,
  output logic pulse_cmd_out,
  output logic brake_engage_out
);
  import scc_pkg::*;

  logic [31:0] regs_q [`SCC_NUM_WR];
  logic [31:0] regs_d [`SCC_NUM_WR];
  logic aw_rdy_q, aw_rdy_d, b_valid_q, b_valid_d, ar_rdy_q, ar_rdy_d, r_valid_q, r_valid_d;
  logic [1:0] b_resp_q, b_resp_d, r_resp_q, r_resp_d;
  logic [31:0] r_data_q, r_data_d;
  logic w_hs, r_hs;
  logic [3:0] wix, rix;

  scc_pins_t sync1_q, sync2_q;
  logic [16:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  logic pulse_q, pulse_d;
  logic signed [15:0] trq_q, trq_d;
  logic signed [15:0] spd_cmd;
  logic ccw_hit_q, ccw_hit_d, cw_hit_q, cw_hit_d;
  logic signed [39:0] filt_q, filt_d;
  scc_brk_t brk_st_q, brk_st_d;
  logic [11:0] brk_cnt_q, brk_cnt_d;
  logic brk_q, brk_d;

  logic [2:0] mode;
  logic src_analog, torque_dir, speed_dir, jog_mode;
  scc_lim_t int_lim, ext_lim, jog_lim;
  scc_ofs_t ofs;
  scc_pair_t acc_dec, scrv;
  scc_fb_t fb;
  scc_ctrl_raw_t ctrl;
  logic [7:0] pulse_sel;

  assign ctrl = scc_ctrl_raw_t'(regs_q[`SCC_IX_CTRL]);
  assign mode = ctrl.control_mode_select;
  assign src_analog = ctrl.speed_source_select;
  assign torque_dir = ctrl.torque_dir;
  assign speed_dir = ctrl.speed_dir;
  assign jog_mode = ctrl.jog_mode;
  assign pulse_sel = regs_q[`SCC_IX_PULSE][7:0];
  assign int_lim = scc_lim_t'(regs_q[`SCC_IX_INT_LIM]);
  assign ext_lim = scc_lim_t'(regs_q[`SCC_IX_EXT_LIM]);
  assign jog_lim = scc_lim_t'(regs_q[`SCC_IX_JOG_LIM]);
  assign ofs = scc_ofs_t'(regs_q[`SCC_IX_OFS]);
  assign acc_dec = scc_pair_t'(regs_q[`SCC_IX_ACC_DEC]);
  assign scrv = scc_pair_t'(regs_q[`SCC_IX_SCRV]);
  assign fb = scc_fb_t'(regs_q[`SCC_IX_FILT_BRK]);

  function automatic logic [31:0] rst_val(input int i);
    unique case (i)
      0: rst_val = `SCC_RST_CTRL;
      1: rst_val = `SCC_RST_PULSE;
      2: rst_val = `SCC_RST_INT_LIM;
      3: rst_val = `SCC_RST_EXT_LIM;
      4: rst_val = `SCC_RST_JOG_LIM;
      5: rst_val = `SCC_RST_OFS;
      6: rst_val = `SCC_RST_ACC_DEC;
      7: rst_val = `SCC_RST_SCRV;
      default: rst_val = `SCC_RST_FILT_BRK;
    endcase
  endfunction : rst_val

  // Register bus: address and data are taken together, one write and one read at a time
  assign wix = s_axi_awaddr_in[5:2];
  assign rix = s_axi_araddr_in[5:2];
  always_comb begin
    aw_rdy_d = ~aw_rdy_q & ~b_valid_q & s_axi_awvalid_in & s_axi_wvalid_in;
    w_hs = aw_rdy_q & s_axi_awvalid_in & s_axi_wvalid_in;
    b_valid_d = w_hs | (b_valid_q & ~s_axi_bready_in);
    b_resp_d = b_resp_q;
    regs_d = regs_q;
    if (w_hs) begin
      if (s_axi_awaddr_in[7:6] == 2'h0 && wix < 4'(`SCC_NUM_WR)) begin
        b_resp_d = `SCC_RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (s_axi_wstrb_in[b]) begin
            regs_d[wix][8*b +: 8] = s_axi_wdata_in[8*b +: 8];
          end
        end
      end else begin
        b_resp_d = `SCC_RESP_SLVERR;
      end
    end
    ar_rdy_d = ~ar_rdy_q & ~r_valid_q & s_axi_arvalid_in;
    r_hs = ar_rdy_q & s_axi_arvalid_in;
    r_valid_d = r_hs | (r_valid_q & ~s_axi_rready_in);
    r_data_d = r_data_q;
    r_resp_d = r_resp_q;
    if (r_hs) begin
      r_resp_d = `SCC_RESP_OKAY;
      r_data_d = 32'h0;
      if (s_axi_araddr_in[7:6] != 2'h0) begin
        r_resp_d = `SCC_RESP_SLVERR;
      end else if (rix < 4'(`SCC_NUM_WR)) begin
        r_data_d = regs_q[rix];
      end else if (rix == `SCC_IX_STATUS) begin
        r_data_d = {26'h0, brk_st_q, pulse_sel == `SCC_PULSE_NEG, cw_hit_q, ccw_hit_q, brk_q};
      end else if (rix == `SCC_IX_SPEED) begin
        r_data_d = 32'(spd_cmd);
      end else if (rix == `SCC_IX_TORQUE) begin
        r_data_d = 32'(trq_q);
      end else begin
        r_resp_d = `SCC_RESP_SLVERR;
      end
    end
  end

  // Millisecond tick and pulse polarity
  always_comb begin
    tick_d = (tick_cnt_q == 17'(MS_CYCLES - 1));
    tick_cnt_d = tick_d ? 17'h0 : tick_cnt_q + 17'h1;
    // Any code other than the two documented ones keeps positive logic
    pulse_d = (pulse_sel == `SCC_PULSE_NEG) ? ~sync2_q.pulse_cmd : sync2_q.pulse_cmd;
  end

  // Torque path, positive is CCW, units of 0.1 percent
  logic signed [17:0] trq_sum, trq_dir, ccw_lim, cw_lim;
  logic signed [17:0] int_ccw, int_cw, ext_ccw, ext_cw, jog_ccw;
  always_comb begin
    trq_sum = 18'(ana_in.torque_raw) + 18'(ofs.trq);
    trq_dir = torque_dir ? -trq_sum : trq_sum;
    // Signed products throughout, so negative CW limits compare in the right order
    int_ccw = $signed(18'(int_lim.ccw)) * $signed(18'(`SCC_PCT_SCALE));
    int_cw = 18'(int_lim.cw) * $signed(18'(`SCC_PCT_SCALE));
    ext_ccw = $signed(18'(ext_lim.ccw)) * $signed(18'(`SCC_PCT_SCALE));
    ext_cw = 18'(ext_lim.cw) * $signed(18'(`SCC_PCT_SCALE));
    jog_ccw = $signed(18'(jog_lim.ccw)) * $signed(18'(`SCC_PCT_SCALE));
    ccw_lim = int_ccw;
    cw_lim = int_cw;
    if (sync2_q.ext_ccw_torque_limit_input && ext_ccw < ccw_lim) begin
      ccw_lim = ext_ccw;
    end
    if (sync2_q.ext_cw_torque_limit_input && ext_cw > cw_lim) begin
      cw_lim = ext_cw;
    end
    if (jog_mode && jog_ccw < ccw_lim) begin
      ccw_lim = jog_ccw;
    end
    if (jog_mode && -jog_ccw > cw_lim) begin
      cw_lim = -jog_ccw;
    end
    ccw_hit_d = trq_dir > ccw_lim;
    cw_hit_d = trq_dir < cw_lim;
    trq_d = ccw_hit_d ? 16'(ccw_lim) : cw_hit_d ? 16'(cw_lim) : 16'(trq_dir);
  end

  // Speed path, filtered in 1/65536 r/min
  logic signed [31:0] spd_scaled;
  logic signed [39:0] spd_fix, spd_filt_full;
  logic signed [15:0] spd_filt, spd_lin;
  logic filt_on, analog_on;
  always_comb begin
    analog_on = src_analog && (mode == `SCC_MODE_SPEED || mode == `SCC_MODE_SPD_TRQ);
    spd_scaled = (32'(ana_in.speed_mv) + 32'(ofs.spd))
                 * $signed(32'(scrv.hi)) / `SCC_GAIN_DIV;
    spd_fix = analog_on ? 40'(spd_scaled) <<< `SCC_RPM_FRAC : 40'h0;
    filt_on = (mode == `SCC_MODE_SPD_TRQ && src_analog) || mode == `SCC_MODE_TORQUE;
    filt_d = filt_q;
    if (!filt_on || fb.filt_ms == 10'h0) begin
      filt_d = spd_fix;
    end else if (tick_q) begin
      filt_d = filt_q + (spd_fix - filt_q) / $signed(40'(fb.filt_ms) + 40'h1);
    end
    spd_filt_full = speed_dir ? -(filt_q >>> `SCC_RPM_FRAC) : filt_q >>> `SCC_RPM_FRAC;
    spd_filt = 16'(spd_filt_full);
  end

  scc_ramp u_linear (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick_q),
    .en_in(mode == `SCC_MODE_SPEED),
    .target_in(spd_filt),
    .up_ms_in(acc_dec.lo),
    .dn_ms_in(acc_dec.hi),
    .value_out(spd_lin)
  );

  // A rate-limited second stage rounds the corners of the linear ramp
  scc_ramp u_scurve (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick_q),
    .en_in(1'b1),
    .target_in(spd_lin),
    .up_ms_in(scrv.lo),
    .dn_ms_in(scrv.lo),
    .value_out(spd_cmd)
  );

  // Brake timing, counted in millisecond ticks
  always_comb begin
    brk_st_d = brk_st_q;
    brk_cnt_d = brk_cnt_q;
    unique case (brk_st_q)
      SCC_BRK_ENGAGED: begin
        if (sync2_q.servo_on) begin
          brk_st_d = SCC_BRK_RELEASING;
          brk_cnt_d = 12'h0;
        end
      end
      SCC_BRK_RELEASING: begin
        if (!sync2_q.servo_on) begin
          brk_st_d = SCC_BRK_ENGAGED;
        end else if (brk_cnt_q >= 12'(fb.off_dly) * `SCC_BRK_STEP_MS) begin
          brk_st_d = SCC_BRK_RELEASED;
        end else if (tick_q) begin
          brk_cnt_d = brk_cnt_q + 12'h1;
        end
      end
      SCC_BRK_RELEASED: begin
        if (!sync2_q.servo_on) begin
          brk_st_d = SCC_BRK_ENGAGING;
          brk_cnt_d = 12'h0;
        end
      end
      SCC_BRK_ENGAGING: begin
        if (sync2_q.servo_on) begin
          brk_st_d = SCC_BRK_RELEASED;
        end else if (brk_cnt_q >= 12'(fb.on_dly) * `SCC_BRK_STEP_MS) begin
          brk_st_d = SCC_BRK_ENGAGED;
        end else if (tick_q) begin
          brk_cnt_d = brk_cnt_q + 12'h1;
        end
      end
    endcase
    brk_d = (brk_st_d == SCC_BRK_ENGAGED) || (brk_st_d == SCC_BRK_RELEASING);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < `SCC_NUM_WR; i++) begin
        regs_q[i] <= rst_val(i);
      end
      aw_rdy_q <= 1'b0;
      b_valid_q <= 1'b0;
      b_resp_q <= `SCC_RESP_OKAY;
      ar_rdy_q <= 1'b0;
      r_valid_q <= 1'b0;
      r_resp_q <= `SCC_RESP_OKAY;
      r_data_q <= 32'h0;
      sync1_q <= '0;
      sync2_q <= '0;
      tick_cnt_q <= 17'h0;
      tick_q <= 1'b0;
      pulse_q <= 1'b0;
      trq_q <= 16'h0;
      ccw_hit_q <= 1'b0;
      cw_hit_q <= 1'b0;
      filt_q <= 40'h0;
      brk_st_q <= SCC_BRK_ENGAGED;
      brk_cnt_q <= 12'h0;
      brk_q <= 1'b1;
    end else begin
      regs_q <= regs_d;
      aw_rdy_q <= aw_rdy_d;
      b_valid_q <= b_valid_d;
      b_resp_q <= b_resp_d;
      ar_rdy_q <= ar_rdy_d;
      r_valid_q <= r_valid_d;
      r_resp_q <= r_resp_d;
      r_data_q <= r_data_d;
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      pulse_q <= pulse_d;
      trq_q <= trq_d;
      ccw_hit_q <= ccw_hit_d;
      cw_hit_q <= cw_hit_d;
      filt_q <= filt_d;
      brk_st_q <= brk_st_d;
      brk_cnt_q <= brk_cnt_d;
      brk_q <= brk_d;
    end
  end

  assign s_axi_awready_out = aw_rdy_q;
  assign s_axi_wready_out = aw_rdy_q;
  assign s_axi_bvalid_out = b_valid_q;
  assign s_axi_bresp_out = b_resp_q;
  assign s_axi_arready_out = ar_rdy_q;
  assign s_axi_rvalid_out = r_valid_q;
  assign s_axi_rdata_out = r_data_q;
  assign s_axi_rresp_out = r_resp_q;
  assign cmd_out = {spd_cmd, trq_q};
  assign pulse_cmd_out = pulse_q;
  assign brake_engage_out = brk_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_int_ccw_clamp: assert property (##1 trq_q <= $past(int_ccw))
    else $error("torque above internal CCW limit");
  a_int_cw_clamp: assert property (##1 trq_q >= $past(int_cw))
    else $error("torque below internal CW limit");
  a_ext_ccw_clamp: assert property (sync2_q.ext_ccw_torque_limit_input
    |=> trq_q <= $past(ext_ccw))
    else $error("torque above external CCW limit");
  a_ext_cw_clamp: assert property (sync2_q.ext_cw_torque_limit_input
    |=> trq_q >= $past(ext_cw))
    else $error("torque below external CW limit");
  a_jog_clamp: assert property (jog_mode
    |=> trq_q <= $past(jog_ccw) && trq_q >= -$past(jog_ccw))
    else $error("torque outside JOG limit");
  a_pulse_neg: assert property (pulse_sel == `SCC_PULSE_NEG
    |=> pulse_q == !$past(sync2_q.pulse_cmd))
    else $error("pulse not inverted for negative logic");
  a_pulse_pos: assert property (pulse_sel == `SCC_PULSE_POS
    |=> pulse_q == $past(sync2_q.pulse_cmd))
    else $error("pulse altered under positive logic");
  a_brk_release: assert property ($rose(sync2_q.servo_on) && fb.off_dly == 8'h0
    && brk_st_q == SCC_BRK_ENGAGED |-> ##2 !brk_q)
    else $error("brake not released after zero delay");
  a_brk_engage: assert property ($fell(sync2_q.servo_on) && fb.on_dly == 8'h0
    && brk_st_q == SCC_BRK_RELEASED |-> ##2 brk_q)
    else $error("brake not engaged after zero delay");
endmodule : scc_top

/* File: shared/scc_pkg.sv */
// Types shared by the command conditioner files
package scc_pkg;
  typedef struct packed {
    logic [24:0] rsvd;
    logic jog_mode;
    logic speed_dir;
    logic torque_dir;
    logic speed_source_select;
    logic [2:0] control_mode_select;
  } scc_ctrl_raw_t;
  typedef struct packed {
    logic [5:0] r1;
    logic signed [9:0] cw;
    logic [5:0] r0;
    logic [9:0] ccw;
  } scc_lim_t;
  typedef struct packed {
    logic [3:0] r1;
    logic signed [11:0] spd;
    logic [3:0] r0;
    logic signed [11:0] trq;
  } scc_ofs_t;
  typedef struct packed {
    logic [1:0] r1;
    logic [13:0] hi;
    logic [1:0] r0;
    logic [13:0] lo;
  } scc_pair_t;
  typedef struct packed {
    logic [7:0] off_dly;
    logic [7:0] on_dly;
    logic [5:0] r0;
    logic [9:0] filt_ms;
  } scc_fb_t;
  typedef struct packed {
    logic ext_ccw_torque_limit_input;
    logic ext_cw_torque_limit_input;
    logic pulse_cmd;
    logic servo_on;
  } scc_pins_t;
  typedef struct packed {
    logic signed [15:0] torque_raw;
    logic signed [15:0] speed_mv;
  } scc_ana_t;
  typedef struct packed {
    logic signed [15:0] speed_rpm;
    logic signed [15:0] torque_pmil;
  } scc_cmd_t;
  typedef enum logic [1:0] {
    SCC_BRK_ENGAGED = 2'b00,
    SCC_BRK_RELEASING = 2'b01,
    SCC_BRK_RELEASED = 2'b10,
    SCC_BRK_ENGAGING = 2'b11
  } scc_brk_t;
endpackage : scc_pkg

/* File: shared/scc_regs.svh */
// Register map, reset values and timing constants of the command conditioner
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// Timing
`define SCC_CLK_NS 10
`define SCC_MS_NS 1000000
`define SCC_BRK_STEP_MS 12'h00A
`define SCC_RAMP_RPM 40'h00000003E8
`define SCC_RPM_FRAC 16
`define SCC_GAIN_DIV 1000
`define SCC_PCT_SCALE 13'h000A

// Register indices, byte address is four times the index
`define SCC_IX_CTRL 4'h0
`define SCC_IX_PULSE 4'h1
`define SCC_IX_INT_LIM 4'h2
`define SCC_IX_EXT_LIM 4'h3
`define SCC_IX_JOG_LIM 4'h4
`define SCC_IX_OFS 4'h5
`define SCC_IX_ACC_DEC 4'h6
`define SCC_IX_SCRV 4'h7
`define SCC_IX_FILT_BRK 4'h8
`define SCC_IX_STATUS 4'h9
`define SCC_IX_SPEED 4'hA
`define SCC_IX_TORQUE 4'hB
`define SCC_NUM_WR 9

// Reset values
`define SCC_RST_CTRL 32'h00000000
`define SCC_RST_PULSE 32'h000000A7
`define SCC_RST_INT_LIM 32'h033800C8
`define SCC_RST_EXT_LIM 32'h02D4012C
`define SCC_RST_JOG_LIM 32'h0000012C
`define SCC_RST_OFS 32'h00000000
`define SCC_RST_ACC_DEC 32'h00640064
`define SCC_RST_SCRV 32'h012C0001
`define SCC_RST_FILT_BRK 32'h00000000

// Codes
`define SCC_PULSE_POS 8'hA7
`define SCC_PULSE_NEG 8'hB3
`define SCC_MODE_SPEED 3'h1
`define SCC_MODE_TORQUE 3'h2
`define SCC_MODE_SPD_TRQ 3'h4
`define SCC_RESP_OKAY 2'h0
`define SCC_RESP_SLVERR 2'h2

`endif

/* File: tb/scc_host.sv */
// Host controller model that registers the bench commands and drives the terminals and analog samples
module scc_host
  import scc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Bench commands
  input wire logic servo_on_in,
  input wire logic ccw_lim_in,
  input wire logic cw_lim_in,
  input wire logic pulse_in,
  input wire logic signed [15:0] torque_in,
  input wire logic signed [15:0] speed_in,
  // Drive side
  output scc_pkg::scc_pins_t pins_out,
  output scc_pkg::scc_ana_t ana_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Start from known levels so the drive never sees unknown terminals
  scc_pins_t pins_q = '0;
  scc_ana_t ana_q = '0;
  // Outputs change just after an edge, as a real controller output stage would
  always @(posedge clk_in) begin
    pins_q <= {ccw_lim_in, cw_lim_in, pulse_in, servo_on_in};
    ana_q <= {torque_in, speed_in};
  end
  assign pins_out = pins_q;
  assign ana_out = ana_q;
endmodule : scc_host

/* File: tb/scc_top_tb.sv */
// Self-checking bench for the servo command conditioner
module scc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h00000000, rdv;
  logic [1:0] rs;
  logic [3:0] w_s = 4'hF;
  logic son = 1'b0, ccw = 1'b0, cw = 1'b0, pul = 1'b0;
  logic signed [15:0] tq = 16'sh0000, sp = 16'sh0000;
  logic awr, wr_o, bv, arr, rv, pulse_o, brk;
  logic [1:0] br, rr;
  logic [31:0] rd_o;
  scc_pins_t pins;
  scc_ana_t ana;
  scc_cmd_t cmd;
  int err_count = 0;
  int check_count = 0;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [31:0] rv_t [9] = '{32'h00000000, 32'h000000A7, 32'h033800C8, 32'h02D4012C,
    32'h0000012C, 32'h00000000, 32'h00640064, 32'h012C0001, 32'h00000000};
  always #5 clk_in = ~clk_in;
  scc_host host (.clk_in(clk_in), .servo_on_in(son), .ccw_lim_in(ccw), .cw_lim_in(cw),
    .pulse_in(pul), .torque_in(tq), .speed_in(sp), .pins_out(pins), .ana_out(ana));
  // Short millisecond keeps the ramps and brake delays within a brief run
  scc_top #(.MS_CYCLES(20)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awvalid_in(aw_v), .s_axi_awready_out(awr), .s_axi_awaddr_in(aw_a),
    .s_axi_wvalid_in(w_v), .s_axi_wready_out(wr_o), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(w_s), .s_axi_bvalid_out(bv), .s_axi_bready_in(b_r),
    .s_axi_bresp_out(br), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ar_a), .s_axi_rvalid_out(rv), .s_axi_rready_in(r_r),
    .s_axi_rdata_out(rd_o), .s_axi_rresp_out(rr), .pins_in(pins), .ana_in(ana),
    .cmd_out(cmd), .pulse_cmd_out(pulse_o), .brake_engage_out(brk));
  task automatic check(input string nm, input logic signed [31:0] e, input logic signed [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    aw_a <= a;
    w_d <= d;
    b_r <= 1'b1;
    // Each channel is released at the edge that takes it
    while (!(aw_done && w_done)) begin
      @(posedge clk_in);
      if (!aw_done && awr === 1'b1) begin
        aw_v <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wr_o === 1'b1) begin
        w_v <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge clk_in); while (bv !== 1'b1);
    rs = br;
    b_r <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ar_v <= 1'b1;
    ar_a <= a;
    r_r <= 1'b1;
    do @(posedge clk_in); while (arr !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge clk_in); while (rv !== 1'b1);
    rdv = rd_o;
    rs = rr;
    r_r <= 1'b0;
    @(posedge clk_in);
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_n
  // Torque sample in, settled conditioned torque compared
  task automatic trq(input logic signed [15:0] v, input logic signed [31:0] e);
    tq <= v;
    wait_n(8);
    check("torque", e, cmd.torque_pmil);
  endtask : trq
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    wait_n(60000);
    err_count++;
    conclude();
  end
  initial begin
    wait_n(8);
    rst_in <= 1'b0;
    wait_n(1);
    check("brake at reset", 1, brk);
    for (int i = 0; i < 9; i++) begin
      rd(ra[i]);
      check("reset value", rv_t[i], rdv);
    end
    rd(8'h30);
    check("unmapped resp", 2, rs);
    check("unmapped data", 0, rdv);
    wr(8'h24, 32'h0000FFFF);
    check("read-only resp", 2, rs);
    // Only the strobed byte lane may change
    w_s <= 4'h2;
    wr(8'h04, 32'h0000FFB3);
    w_s <= 4'hF;
    rd(8'h04);
    check("byte lane", 32'h0000FFA7, rdv);
    // Pulse polarity, default positive then inverted
    pul <= 1'b1;
    wait_n(8);
    check("pulse positive", 1, pulse_o);
    wr(8'h04, 32'h000000B3);
    wait_n(4);
    check("pulse negative", 0, pulse_o);
    wr(8'h04, 32'h000000A7);
    wait_n(4);
    check("pulse restored", 1, pulse_o);
    // Torque mode, 300 % samples against the limits, then a 50 % sample with the offset
    wr(8'h00, 32'h00000002);
    trq(16'sd3000, 2000);
    trq(-16'sd3000, -2000);
    wr(8'h00, 32'h00000012);
    trq(16'sd3000, -2000);
    wr(8'h00, 32'h00000002);
    wr(8'h0C, 32'h039C0096);
    ccw <= 1'b1;
    trq(16'sd3000, 1500);
    ccw <= 1'b0;
    trq(16'sd3000, 2000);
    cw <= 1'b1;
    trq(-16'sd3000, -1000);
    cw <= 1'b0;
    wr(8'h10, 32'h00000032);
    wr(8'h00, 32'h00000042);
    ccw <= 1'b1;
    trq(16'sd3000, 500);
    trq(-16'sd3000, -500);
    ccw <= 1'b0;
    wr(8'h00, 32'h00000002);
    wr(8'h14, 32'h00000F9C);
    trq(16'sd500, 400);
    // Speed mode, analog source, default gain: 1000 mV gives 300 r/min
    wr(8'h00, 32'h00000009);
    sp <= 16'sd1000;
    wait_n(200);
    check("accel ramping", 1, cmd.speed_rpm > 0 && cmd.speed_rpm < 300);
    wait_n(1200);
    check("speed gain", 300, cmd.speed_rpm);
    wr(8'h00, 32'h00000029);
    wait_n(400);
    check("decel ramping", 1, cmd.speed_rpm > -300 && cmd.speed_rpm < 300);
    wait_n(2000);
    check("speed direction", -300, cmd.speed_rpm);
    wr(8'h00, 32'h00000009);
    wr(8'h14, 32'h00640000);
    wait_n(2500);
    check("speed offset", 330, cmd.speed_rpm);
    // Brake: release waits 2 x 10 ms, engage waits 1 x 10 ms
    wr(8'h20, 32'h02010000);
    son <= 1'b1;
    wait_n(385);
    check("brake held", 1, brk);
    wait_n(40);
    check("brake released", 0, brk);
    son <= 1'b0;
    wait_n(185);
    check("brake still off", 0, brk);
    wait_n(40);
    check("brake engaged", 1, brk);
    // Speed/torque mode with analog source: filter slows a step from 330 to 630 r/min
    wr(8'h00, 32'h0000000C);
    wr(8'h20, 32'h02010014);
    sp <= 16'sd2000;
    wait_n(200);
    check("filter lag", 1, cmd.speed_rpm > 330 && cmd.speed_rpm < 630);
    wr(8'h20, 32'h02010000);
    wait_n(40);
    check("filter off", 630, cmd.speed_rpm);
    conclude();
  end
endmodule : scc_top_tb
